// File: logic/spm_consts.svh
//----------------------------------------------------------------------
// Purpose: Register map, field positions, reset values and timing
//          constants of the serial port pin and mode control block.
// Assumes: APB register slave, one aligned 32-bit word per register.
// Notes:   Constants are macros; types live in spm_pkg.
//----------------------------------------------------------------------
// Contract
// - Disabled port releases all four pins.
// - Slave takes clock in, master drives it.
// - Two-wire data pins follow master or slave role.
// - Single-wire master uses master pin, direction bit.
// - Single-wire slave releases the master pin.
// - Single-wire slave uses slave pin, direction bit.
// - Single-wire master releases the slave pin.
// - Slave treats select pin as active-low input.
// - Master select pin: GPIO, fault input, or output.
// - Every stop mode disables the port.
// - Deep stop returns the port to reset.
// - Light stop holds all state and clocks.
// - Bit 7 enables receive-full and fault interrupt.
// - Clearing enable aborts, clears buffers and receive/transmit flags.
// - Bit 5 enables transmit-empty interrupt.
// - Bit 4 selects master (1) or slave (0).
// - Bit 3 inverts the clock, setting idle level.
// - Bit 2 places first clock edge mid or start.
// - Bit 0 selects low bit first shifting.
// - Bit 1 helps select the select-pin function.
// - Five software-visible 8-bit registers.
// - Mode-fault enable gates fault and select output.
// - Second control bit 0 single-wire, bit 3 direction.
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

`define SPM_OFS_CTRL1   8'h00
`define SPM_OFS_CTRL2   8'h04
`define SPM_OFS_BAUD    8'h08
`define SPM_OFS_STATUS  8'h0C
`define SPM_OFS_DATA    8'h10

`define SPM_C1_RXIE     7
`define SPM_C1_EN       6
`define SPM_C1_TXIE     5
`define SPM_C1_MASTER_SELECT     4
`define SPM_C1_CLOCK_POLARITY     3
`define SPM_C1_CLOCK_PHASE     2
`define SPM_C1_SELECT_OUTPUT_ENABLE     1
`define SPM_C1_LSBF     0

`define SPM_C2_MODE_FAULT_ENABLE   4
`define SPM_C2_BIDIR_OUTPUT_ENABLE  3
`define SPM_C2_SINGLE_WIRE_SELECT     0
`define SPM_C2_MASK     8'h1B
`define SPM_BAUD_MASK   8'h77

`define SPM_ST_RXF      7
`define SPM_ST_TXE      5
`define SPM_ST_MODE_FAULT_FLAG     4

`define SPM_RST_CTRL1   8'h04
`define SPM_RST_CTRL2   8'h00
`define SPM_RST_BAUD    8'h00

`define SPM_PIN_SCK     0
`define SPM_PIN_MOSI    1
`define SPM_PIN_MISO    2
`define SPM_PIN_SS      3

`define SPM_LAST_EDGE   5'h0F

`endif

// File: logic/spm_pkg.sv
//----------------------------------------------------------------------
// Purpose: Types of the serial port pin and mode control block.
// Assumes: Used with spm_consts.svh.
// Notes:   The whole module state is one packed struct.
//----------------------------------------------------------------------
package spm_pkg;

   typedef struct packed {
      logic [7:0]  ctrl1;
      logic [7:0]  ctrl2;
      logic [7:0]  baud;
      logic [7:0]  txbuf;
      logic [7:0]  rxbuf;
      logic [7:0]  tx_sh;
      logic [7:0]  rx_sh;
      logic        tx_full;
      logic        rx_full;
      logic        mode_fault_flag;
      logic        rxf_arm;
      logic        mode_fault_flag_arm;
      logic        busy;
      logic        sclk_lvl;
      logic        stop_q;
      logic [4:0]  edge_cnt;
      logic [10:0] div_cnt;
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [3:0]  s3;
      logic [3:0]  flt;
      logic [3:0]  pin_o;
      logic [3:0]  pin_oe;
      logic [3:0]  own;
      logic        irq;
      logic        rdy;
      logic        slverr;
      logic [31:0] rdata;
   } spm_st_t;

endpackage

// File: logic/spm_port_ctrl.sv
//----------------------------------------------------------------------
// Purpose: Serial port with master/slave pin routing, single-wire mode,
//          select pin handling, stop-mode behaviour and APB registers.
// Assumes: clk_sys at 200 MHz is the bus clock; pins are asynchronous.
// Notes:   APB answers with one wait state; all outputs are registered.
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "spm_consts.svh"

module spm_port_ctrl
   import spm_pkg::*;
(
   input  wire logic        clk_sys,             // System clock.
   input  wire logic        arst_n,              // Async reset, low.
   input  wire logic        psel,                // APB select.
   input  wire logic        penable,             // APB enable.
   input  wire logic        pwrite,              // APB write.
   input  wire logic [7:0]  paddr,               // APB byte address.
   input  wire logic [31:0] pwdata,              // APB write data.
   input  wire logic [3:0]  pstrb,               // APB byte strobes.
   output logic      [31:0] prdata,              // APB read data.
   output logic             pready,              // APB ready.
   output logic             pslverr,             // APB error.
   input  wire logic        stop_light,          // Light stop level.
   input  wire logic        stop_deep,           // Deep stop level.
   input  wire logic        serial_clock_pin_in, // Clock pin level.
   output logic             serial_clock_pin_out,// Clock pin drive.
   output logic             serial_clock_pin_oe, // Clock pin enable.
   input  wire logic        mosi_pin_in,         // Master-out pin.
   output logic             mosi_pin_out,        // Master-out drive.
   output logic             mosi_pin_oe,         // Master-out enable.
   input  wire logic        miso_pin_in,         // Master-in pin.
   output logic             miso_pin_out,        // Master-in drive.
   output logic             miso_pin_oe,         // Master-in enable.
   input  wire logic        ss_n_pin_in,         // Select pin level.
   output logic             ss_n_pin_out,        // Select pin drive.
   output logic             ss_n_pin_oe,         // Select pin enable.
   output logic      [3:0]  pin_owned,           // Pin held by port.
   output logic             irq                  // Interrupt request.
);

   //-------------------------------------------------------------------
   // State and reset value
   //-------------------------------------------------------------------
   function automatic spm_st_t rst_state();
      spm_st_t s;
      s        = '0;
      s.ctrl1  = `SPM_RST_CTRL1;
      s.ctrl2  = `SPM_RST_CTRL2;
      s.baud   = `SPM_RST_BAUD;
      s.s1     = 4'hF;
      s.s2     = 4'hF;
      s.s3     = 4'hF;
      s.flt    = 4'hF;
      return s;
   endfunction

   localparam spm_st_t ST_RST = rst_state();

   spm_st_t     r_reg;
   spm_st_t     r_next;
   logic [3:0]  pin_in;
   logic        acc;
   logic        wr_done;
   logic        rd_done;
   logic        mapped;
   logic [7:0]  rd_val;
   logic [10:0] half;
   logic        din;
   logic        do_edge;
   logic        samp;
   logic [7:0]  rx_new;
   logic        rx_set;
   logic        act;
   logic        mst;

   assign pin_in = {ss_n_pin_in, miso_pin_in, mosi_pin_in,
                    serial_clock_pin_in};

   //-------------------------------------------------------------------
   // Next state
   //-------------------------------------------------------------------
   always_comb begin
      r_next  = r_reg;
      acc     = psel && penable;
      wr_done = acc && r_reg.rdy && pwrite;
      rd_done = acc && r_reg.rdy && !pwrite;
      mapped  = 1'b1;
      rd_val  = 8'h00;
      half    = 11'({7'h0, 4'({1'b0, r_reg.baud[6:4]} + 4'h1)}
                << r_reg.baud[2:0]);
      din     = 1'b0;
      do_edge = 1'b0;
      samp    = 1'b0;
      rx_new  = r_reg.rx_sh;
      rx_set  = 1'b0;
      act     = 1'b0;
      mst     = 1'b0;

      // Pins are resynchronised; a change counts once stages 2 and 3
      // agree.
      for (int i = 0; i < 4; i++) begin
         r_next.s1[i] = pin_in[i];
         r_next.s2[i] = r_reg.s1[i];
         r_next.s3[i] = r_reg.s2[i];
         if (r_reg.s2[i] == r_reg.s3[i]) begin
            r_next.flt[i] = r_reg.s3[i];
         end
      end

      // Shift engine.
      if (r_reg.ctrl1[`SPM_C1_EN]) begin
         if (r_reg.ctrl1[`SPM_C1_MASTER_SELECT]) begin
            din = r_reg.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT] ? r_next.flt[`SPM_PIN_MOSI]
                                            : r_next.flt[`SPM_PIN_MISO];
            if (!r_reg.busy) begin
               if (r_reg.tx_full) begin
                  r_next.tx_sh    = r_reg.txbuf;
                  r_next.tx_full  = 1'b0;
                  r_next.busy     = 1'b1;
                  r_next.edge_cnt = 5'h00;
                  r_next.div_cnt  = 11'h000;
               end
            end else if (r_reg.div_cnt == half - 11'h001) begin
               r_next.div_cnt  = 11'h000;
               r_next.sclk_lvl = !r_reg.sclk_lvl;
               do_edge         = 1'b1;
            end else begin
               r_next.div_cnt = r_reg.div_cnt + 11'h001;
            end
         end else begin
            din = r_reg.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT] ? r_next.flt[`SPM_PIN_MISO]
                                            : r_next.flt[`SPM_PIN_MOSI];
            if (r_next.flt[`SPM_PIN_SS]) begin
               r_next.busy     = 1'b0;
               r_next.edge_cnt = 5'h00;
            end else if (!r_reg.busy) begin
               r_next.tx_sh    = r_reg.tx_full ? r_reg.txbuf : 8'h00;
               r_next.tx_full  = 1'b0;
               r_next.busy     = 1'b1;
               r_next.edge_cnt = 5'h00;
            end else if (r_next.flt[`SPM_PIN_SCK]
                         != r_reg.flt[`SPM_PIN_SCK]) begin
               do_edge = 1'b1;
            end
         end
      end

      // Even edges lead; phase decides whether a leading edge samples.
      if (do_edge) begin
         samp = r_reg.edge_cnt[0] == r_reg.ctrl1[`SPM_C1_CLOCK_PHASE];
         if (samp) begin
            rx_new = r_reg.ctrl1[`SPM_C1_LSBF]
                     ? {din, r_reg.rx_sh[7:1]}
                     : {r_reg.rx_sh[6:0], din};
            r_next.rx_sh = rx_new;
         end else if (r_reg.edge_cnt != 5'h00) begin
            r_next.tx_sh = r_reg.ctrl1[`SPM_C1_LSBF]
                           ? {1'b0, r_reg.tx_sh[7:1]}
                           : {r_reg.tx_sh[6:0], 1'b0};
         end
         r_next.edge_cnt = r_reg.edge_cnt + 5'h01;
         if (r_reg.edge_cnt == `SPM_LAST_EDGE) begin
            r_next.busy     = 1'b0;
            r_next.edge_cnt = 5'h00;
            if (!r_reg.rx_full) begin
               r_next.rxbuf = rx_new;
               rx_set       = 1'b1;
            end
         end
      end

      // APB slave: first access cycle latches read data, second ends.
      unique case (paddr)
         `SPM_OFS_CTRL1:  rd_val = r_reg.ctrl1;
         `SPM_OFS_CTRL2:  rd_val = r_reg.ctrl2;
         `SPM_OFS_BAUD:   rd_val = r_reg.baud;
         `SPM_OFS_STATUS: rd_val = {r_reg.rx_full, 1'b0, !r_reg.tx_full,
                                    r_reg.mode_fault_flag, 4'h0};
         `SPM_OFS_DATA:   rd_val = r_reg.rxbuf;
         default:         mapped = 1'b0;
      endcase
      r_next.rdy = acc && !r_reg.rdy;
      if (acc && !r_reg.rdy) begin
         r_next.rdata  = {24'h000000, rd_val};
         r_next.slverr = !mapped;
      end
      if (wr_done && pstrb[0]) begin
         unique case (paddr)
            `SPM_OFS_CTRL1: begin
               r_next.ctrl1 = pwdata[7:0];
               if (r_reg.mode_fault_flag_arm) begin
                  r_next.mode_fault_flag     = 1'b0;
                  r_next.mode_fault_flag_arm = 1'b0;
               end
            end
            `SPM_OFS_CTRL2: r_next.ctrl2 = pwdata[7:0] & `SPM_C2_MASK;
            `SPM_OFS_BAUD:  r_next.baud = pwdata[7:0] & `SPM_BAUD_MASK;
            `SPM_OFS_DATA: begin
               r_next.txbuf   = pwdata[7:0];
               r_next.tx_full = 1'b1;
            end
            default: ;
         endcase
      end
      if (rd_done && paddr == `SPM_OFS_STATUS) begin
         r_next.rxf_arm  = r_reg.rx_full;
         r_next.mode_fault_flag_arm = r_reg.mode_fault_flag;
      end
      if (rd_done && paddr == `SPM_OFS_DATA && r_reg.rxf_arm) begin
         r_next.rx_full = 1'b0;
         r_next.rxf_arm = 1'b0;
      end
      if (rx_set) begin
         r_next.rx_full = 1'b1;
      end

      // A master with fault input enabled drops out when selected.
      if (r_reg.ctrl1[`SPM_C1_EN] && r_reg.ctrl1[`SPM_C1_MASTER_SELECT]
          && r_reg.ctrl2[`SPM_C2_MODE_FAULT_ENABLE] && !r_reg.ctrl1[`SPM_C1_SELECT_OUTPUT_ENABLE]
          && !r_next.flt[`SPM_PIN_SS]) begin
         r_next.mode_fault_flag                = 1'b1;
         r_next.ctrl1[`SPM_C1_MASTER_SELECT] = 1'b0;
         r_next.busy                = 1'b0;
         r_next.edge_cnt            = 5'h00;
         r_next.sclk_lvl            = 1'b0;
      end

      if (!r_next.ctrl1[`SPM_C1_EN]) begin
         r_next.busy     = 1'b0;
         r_next.tx_full  = 1'b0;
         r_next.rx_full  = 1'b0;
         r_next.rxf_arm  = 1'b0;
         r_next.txbuf    = 8'h00;
         r_next.rxbuf    = 8'h00;
         r_next.tx_sh    = 8'h00;
         r_next.rx_sh    = 8'h00;
         r_next.edge_cnt = 5'h00;
         r_next.div_cnt  = 11'h000;
         r_next.sclk_lvl = 1'b0;
      end

      if (stop_deep) begin
         r_next = ST_RST;
      end else if (stop_light) begin
         r_next = r_reg;
      end

      // Pin routing from the new state so pins track the registers.
      act            = r_next.ctrl1[`SPM_C1_EN] && !stop_light
                       && !stop_deep;
      mst            = r_next.ctrl1[`SPM_C1_MASTER_SELECT];
      r_next.stop_q  = stop_light || stop_deep;
      r_next.own     = 4'h0;
      r_next.pin_o   = 4'hF;
      r_next.pin_oe  = 4'h0;
      if (act) begin
         r_next.own[`SPM_PIN_SCK] = 1'b1;
         if (mst) begin
            r_next.pin_o[`SPM_PIN_SCK]  = r_next.sclk_lvl
                                          ^ r_next.ctrl1[`SPM_C1_CLOCK_POLARITY];
            r_next.pin_oe[`SPM_PIN_SCK] = 1'b1;
            r_next.own[`SPM_PIN_MOSI]   = 1'b1;
            r_next.pin_o[`SPM_PIN_MOSI] = r_next.ctrl1[`SPM_C1_LSBF]
                                          ? r_next.tx_sh[0]
                                          : r_next.tx_sh[7];
            r_next.pin_oe[`SPM_PIN_MOSI] = !r_next.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT]
                                   || r_next.ctrl2[`SPM_C2_BIDIR_OUTPUT_ENABLE];
            r_next.own[`SPM_PIN_MISO] = !r_next.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT];
            r_next.own[`SPM_PIN_SS]   = r_next.ctrl2[`SPM_C2_MODE_FAULT_ENABLE];
            if (r_next.ctrl2[`SPM_C2_MODE_FAULT_ENABLE]
                && r_next.ctrl1[`SPM_C1_SELECT_OUTPUT_ENABLE]) begin
               r_next.pin_oe[`SPM_PIN_SS] = 1'b1;
               r_next.pin_o[`SPM_PIN_SS]  = !r_next.busy;
            end
         end else begin
            r_next.own[`SPM_PIN_MISO]   = 1'b1;
            r_next.pin_o[`SPM_PIN_MISO] = r_next.ctrl1[`SPM_C1_LSBF]
                                          ? r_next.tx_sh[0]
                                          : r_next.tx_sh[7];
            r_next.pin_oe[`SPM_PIN_MISO] = (!r_next.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT]
                                   || r_next.ctrl2[`SPM_C2_BIDIR_OUTPUT_ENABLE])
                                   && !r_next.flt[`SPM_PIN_SS];
            r_next.own[`SPM_PIN_MOSI] = !r_next.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT];
            r_next.own[`SPM_PIN_SS]   = 1'b1;
         end
      end
      r_next.irq = (r_next.ctrl1[`SPM_C1_RXIE]
                    && (r_next.rx_full || r_next.mode_fault_flag))
                   || (r_next.ctrl1[`SPM_C1_TXIE] && !r_next.tx_full);
   end

   //-------------------------------------------------------------------
   // State register and outputs
   //-------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= ST_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata               = r_reg.rdata;
   assign pready               = r_reg.rdy;
   assign pslverr              = r_reg.slverr;
   assign serial_clock_pin_out = r_reg.pin_o[`SPM_PIN_SCK];
   assign serial_clock_pin_oe  = r_reg.pin_oe[`SPM_PIN_SCK];
   assign mosi_pin_out         = r_reg.pin_o[`SPM_PIN_MOSI];
   assign mosi_pin_oe          = r_reg.pin_oe[`SPM_PIN_MOSI];
   assign miso_pin_out         = r_reg.pin_o[`SPM_PIN_MISO];
   assign miso_pin_oe          = r_reg.pin_oe[`SPM_PIN_MISO];
   assign ss_n_pin_out         = r_reg.pin_o[`SPM_PIN_SS];
   assign ss_n_pin_oe          = r_reg.pin_oe[`SPM_PIN_SS];
   assign pin_owned            = r_reg.own;
   assign irq                  = r_reg.irq;

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_off_release: assert property (
      !r_reg.ctrl1[`SPM_C1_EN] |-> r_reg.own == 4'h0 && r_reg.pin_oe == 4'h0)
      else $error("Disabled port still holds a pin.");

   a_stop_release: assert property (
      r_reg.stop_q |-> r_reg.own == 4'h0)
      else $error("Port holds a pin in stop.");

   a_master_clock: assert property (
      r_reg.ctrl1[`SPM_C1_EN] && r_reg.ctrl1[`SPM_C1_MASTER_SELECT] && !r_reg.stop_q
      |-> serial_clock_pin_oe && r_reg.own[`SPM_PIN_SCK])
      else $error("Master does not drive the clock pin.");

   a_slave_clock_in: assert property (
      !r_reg.ctrl1[`SPM_C1_MASTER_SELECT] |-> !serial_clock_pin_oe)
      else $error("Slave drives the clock pin.");

   a_single_master: assert property (
      r_reg.ctrl1[`SPM_C1_MASTER_SELECT] && r_reg.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT]
      |-> !r_reg.own[`SPM_PIN_MISO] && !miso_pin_oe)
      else $error("Single-wire master holds the slave data pin.");

   a_single_slave: assert property (
      !r_reg.ctrl1[`SPM_C1_MASTER_SELECT] && r_reg.ctrl2[`SPM_C2_SINGLE_WIRE_SELECT]
      |-> !r_reg.own[`SPM_PIN_MOSI] && !mosi_pin_oe)
      else $error("Single-wire slave holds the master data pin.");

   a_slave_select_in: assert property (
      !r_reg.ctrl1[`SPM_C1_MASTER_SELECT] |-> !ss_n_pin_oe)
      else $error("Slave drives the select pin.");

   a_auto_select: assert property (
      r_reg.own[`SPM_PIN_SS] && r_reg.ctrl1[`SPM_C1_MASTER_SELECT]
      && r_reg.ctrl2[`SPM_C2_MODE_FAULT_ENABLE] && r_reg.ctrl1[`SPM_C1_SELECT_OUTPUT_ENABLE]
      |-> ss_n_pin_oe && (ss_n_pin_out == !r_reg.busy))
      else $error("Automatic select output is wrong.");

   a_disable_flags: assert property (
      $fell(r_reg.ctrl1[`SPM_C1_EN]) |-> !r_reg.rx_full && !r_reg.tx_full
      && !r_reg.busy)
      else $error("Disable did not clear flags and transfer.");

   a_irq_merge: assert property (
      irq == ((r_reg.ctrl1[`SPM_C1_RXIE] && (r_reg.rx_full || r_reg.mode_fault_flag))
              || (r_reg.ctrl1[`SPM_C1_TXIE] && !r_reg.tx_full)))
      else $error("Interrupt output disagrees with flags.");

   a_idle_clock: assert property (
      r_reg.own[`SPM_PIN_SCK] && r_reg.ctrl1[`SPM_C1_MASTER_SELECT] && !r_reg.busy
      |-> serial_clock_pin_out == r_reg.ctrl1[`SPM_C1_CLOCK_POLARITY])
      else $error("Idle master clock level is wrong.");

   a_apb_ready: assert property (
      psel && penable && !pready |=> pready)
      else $error("APB access not answered in one wait state.");

endmodule

// File: testbench/spm_slave_model.sv
//----------------------------------------------------------------------
// Purpose: External serial slave facing the port in its master role.
// Assumes: Clock phase 1: shifts on leading, samples on trailing edge.
// Notes:   Between frames the data line shows no held value.
//----------------------------------------------------------------------
`timescale 1ns/1ps
module spm_slave_model (
   input  wire logic       sck,   // Serial clock level.
   input  wire logic       mosi,  // Data from the port.
   input  wire logic       clock_polarity,  // Clock idle level.
   input  wire logic       lsb,   // Low bit first.
   input  wire logic       frame, // Frame active.
   input  wire logic [7:0] reply, // Byte to send.
   output logic            miso,  // Data to the port.
   output logic      [7:0] got    // Byte received.
);
   int idx;
   initial miso = 1'b1;
   always @(frame) begin
      if (!frame) begin
         idx = 0;
         miso = ~miso;
      end
   end
   always @(sck) begin
      if (frame && sck !== clock_polarity) begin
         miso = reply[lsb ? idx : 7 - idx];
      end else if (frame && idx < 8) begin
         got[lsb ? idx : 7 - idx] = mosi;
         idx = idx + 1;
      end
   end
endmodule

// File: testbench/test_spi_pin_mode_control.sv
//----------------------------------------------------------------------
// Purpose: Self-checking bench for the serial port pin and mode block.
// Assumes: One APB wait state; pins resolved from all drivers here.
// Notes:   Select pin has a pull-up; slave link clock is 48 ns.
//----------------------------------------------------------------------
`timescale 1ns/1ps
`include "spm_consts.svh"
module test_spi_pin_mode_control;
   logic        clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 0, reply = 0, tx, b;
   logic [31:0] pwdata = 0, r, seed = 32'hC53B8F2C;
   logic [3:0]  pstrb = 4'hF, pin_owned;
   logic        stop_light = 0, stop_deep = 0, frame = 0, cp = 0, e;
   logic        tb_sck = 0, tb_mosi = 1, tb_ss = 1, sl_miso, irq, pready;
   logic        pslverr, serial_clock_pin_out, serial_clock_pin_oe;
   logic        mosi_pin_out, mosi_pin_oe, miso_pin_out, miso_pin_oe;
   logic        ss_n_pin_out, ss_n_pin_oe;
   logic [31:0] prdata;
   logic [7:0]  got, cap;
   int          err_count = 0, checks_done = 0, n;
   logic [7:0]  exp_q[$];
   wire serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out
                                                  : tb_sck;
   wire mosi_pin_in = mosi_pin_oe ? mosi_pin_out : tb_mosi;
   wire miso_pin_in = miso_pin_oe ? miso_pin_out : sl_miso;
   wire ss_n_pin_in = ss_n_pin_oe ? ss_n_pin_out : tb_ss;

   always #2.5 clk_sys = ~clk_sys;

   spm_port_ctrl dut (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .stop_light, .stop_deep,
      .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe,
      .mosi_pin_in, .mosi_pin_out, .mosi_pin_oe, .miso_pin_in,
      .miso_pin_out, .miso_pin_oe, .ss_n_pin_in, .ss_n_pin_out,
      .ss_n_pin_oe, .pin_owned, .irq);
   spm_slave_model peer (.sck(serial_clock_pin_in), .mosi(mosi_pin_in),
      .clock_polarity(cp), .lsb(cp), .frame(frame), .reply(reply), .miso(sl_miso),
      .got(got));

   //-------------------------------------------------------------------
   // Shared tasks
   //-------------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         err_count++;
         $display("mismatch at %0t: saw %h want %h", $time, s, x);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      r = prdata; e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk_sys);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #100000;
      err_count++;
      complete_run();
   end

   //-------------------------------------------------------------------
   // Scenarios
   //-------------------------------------------------------------------
   initial begin
      wt(8);
      arst_n <= 1;
      apb(0, `SPM_OFS_CTRL1, 0); chk(r, 32'h04);
      apb(0, `SPM_OFS_STATUS, 0); chk(r, 32'h20);
      apb(0, 8'h14, 0); chk(e, 1);
      pstrb <= 4'h0; apb(1, `SPM_OFS_CTRL1, 8'hFF); pstrb <= 4'hF;
      apb(0, `SPM_OFS_CTRL1, 0); chk(r, 32'h04);
      chk(pin_owned, 4'h0);
      for (int i = 0; i < 24; i++) begin
         b = xs();
         apb(1, `SPM_OFS_CTRL2, {b[3], b[2], 2'b0, b[1]});
         apb(1, `SPM_OFS_CTRL1, 8'h44 | b[0] << 4 | b[4] << 1);
         wt(3);
         chk(pin_owned, {~b[0] | b[3], ~(b[1] & b[0]),
             ~(b[1] & ~b[0]), 1'b1});
         chk(serial_clock_pin_oe, b[0]);
         chk(mosi_pin_oe, b[0] & (~b[1] | b[2]));
         chk(ss_n_pin_oe, b[0] & b[3] & b[4]);
         chk(miso_pin_oe, 0);
      end
      apb(1, `SPM_OFS_BAUD, 8'h13);
      for (int k = 0; k < 2; k++) begin
         cp = k[0];
         apb(1, `SPM_OFS_CTRL2, 8'h10);
         apb(1, `SPM_OFS_CTRL1, 8'h56 | k << 3 | k);
         wt(3);
         chk(serial_clock_pin_out, cp);
         tx = xs(); reply = xs(); exp_q.push_back(reply);
         frame = 1;
         apb(1, `SPM_OFS_DATA, tx);
         wt(2); chk(ss_n_pin_out, 0);
         n = 0;
         do apb(0, `SPM_OFS_STATUS, 0); while (!r[7] && n++ < 200);
         chk(r, 32'hA0); chk(irq, 0);
         chk(ss_n_pin_out, 1);
         apb(1, `SPM_OFS_CTRL1, 8'hD6 | k << 3 | k);
         wt(2); chk(irq, 1);
         apb(0, `SPM_OFS_DATA, 0); chk(r, exp_q.pop_front());
         chk(got, tx);
         frame = 0;
         wt(2); chk(irq, 0);
      end
      apb(1, `SPM_OFS_CTRL1, 8'h74); wt(2); chk(irq, 1);
      apb(1, `SPM_OFS_DATA, 8'h5A); wt(20);
      apb(1, `SPM_OFS_CTRL1, 8'h14); wt(2);
      apb(0, `SPM_OFS_STATUS, 0); chk(r, 32'h20);
      chk(pin_owned, 4'h0);
      apb(1, `SPM_OFS_CTRL2, 8'h10);
      apb(1, `SPM_OFS_CTRL1, 8'hD4);
      tb_ss <= 0; wt(8);
      apb(0, `SPM_OFS_STATUS, 0); chk(r, 32'h30); chk(irq, 1);
      apb(0, `SPM_OFS_CTRL1, 0); chk(r, 32'hC4);
      tb_ss <= 1; wt(8);
      apb(1, `SPM_OFS_CTRL2, 0);
      for (int k = 0; k < 2; k++) begin
         apb(1, `SPM_OFS_CTRL1, 8'h40 | k << 2);
         tx = xs(); b = xs();
         apb(1, `SPM_OFS_DATA, tx);
         tb_ss <= 0; #100;
         chk(miso_pin_oe, 1);
         for (int i = 0; i < 8; i++) begin
            tb_mosi <= b[7 - i]; #12;
            tb_sck <= 1; #24;
            tb_sck <= 0; #10;
            cap[7 - i] = miso_pin_in; #2;
         end
         #100 tb_ss <= 1;
         apb(0, `SPM_OFS_STATUS, 0); chk(r, 32'hA0);
         apb(0, `SPM_OFS_DATA, 0); chk(r, b);
         chk(cap, tx);
      end
      stop_light <= 1; wt(5); chk(pin_owned, 4'h0);
      stop_light <= 0; wt(5);
      apb(0, `SPM_OFS_CTRL1, 0); chk(r, 32'h44);
      stop_deep <= 1; wt(3); chk(pin_owned, 4'h0);
      stop_deep <= 0;
      apb(0, `SPM_OFS_CTRL1, 0); chk(r, 32'h04);
      complete_run();
   end
endmodule
